/* File: rtl/chan_mode_pkg.sv */
// Constants for the serial channel mode register block
package chan_mode_pkg;

  // Register byte addresses of the channels that carry a mode register
  localparam logic [19:0] MODE_CH00_ADDR = 20'hf0110;
  localparam logic [19:0] MODE_CH03_ADDR = 20'hf0116;
  localparam logic [19:0] MODE_CH12_ADDR = 20'hf0154;
  localparam logic [19:0] MODE_CH13_ADDR = 20'hf0156;

  // Value after reset and while the unit clock gate is off
  localparam logic [15:0] MODE_RESET_VAL = 16'h0020;
  // Bits that software may change; the rest are fixed
  localparam logic [15:0] MODE_WRITE_MASK = 16'hc147;
  localparam logic [15:0] MODE_FIXED_ONES = 16'h0020;

  // Field positions inside the mode register
  localparam int OP_CLK_SEL_BIT  = 15;
  localparam int SHIFT_SRC_BIT   = 14;
  localparam int START_TRIG_BIT  = 8;
  localparam int RX_INVERT_BIT   = 6;
  localparam int MODE_FIELD_HI   = 2;
  localparam int MODE_FIELD_LO   = 1;
  localparam int IRQ_SRC_BIT     = 0;

  // Prescaler select field positions and encodings
  localparam int PRESC_A_LSB = 0;
  localparam int PRESC_B_LSB = 4;
  localparam int PRESC_CNT_W = 11;
  localparam logic [3:0] PRESC_MAX_POW  = 4'hb;
  localparam logic [3:0] PRESC_EXT_CODE = 4'hf;

  // Operating modes held in bits 2 and 1
  typedef enum logic [1:0] {
    MODE_CSI   = 2'h0,
    MODE_UART  = 2'h1,
    MODE_I2C   = 2'h2,
    MODE_NONE  = 2'h3
  } op_mode_t;

endpackage

/* File: rtl/serial_channel_mode_control.sv */
// Mode register of one serial channel with its clock, start and interrupt selection
`timescale 1ns/100ps
module serial_channel_mode_control
  import chan_mode_pkg::*;
#(
  parameter logic [19:0] CH_ADDR = MODE_CH00_ADDR
)
(
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic [19:0] addr,
  input  wire logic        wr_en,
  input  wire logic        word_access,
  input  wire logic [15:0] wdata,
  input  wire logic        rd_en,
  output logic      [15:0] rdata,
  input  wire logic        unit_clock_gate,
  input  wire logic [7:0]  prescaler_select_reg,
  input  wire logic        timer_tick,
  input  wire logic [6:0]  channel_data_div,
  input  wire logic        channel_running_flag,
  input  wire logic        channel_start_write,
  input  wire logic        sck_pin,
  input  wire logic        rxd_pin,
  input  wire logic        xfer_end_evt,
  input  wire logic        buf_empty_evt,
  output logic      [15:0] channel_mode_reg,
  output logic        channel_op_clock,
  output logic        channel_shift_clock,
  output logic        transfer_start,
  output logic        rx_data,
  output logic        channel_irq,
  output logic [1:0]  op_mode
);

  typedef struct packed {
    logic [15:0]            mode;
    logic [15:0]            rdata;
    logic [PRESC_CNT_W-1:0] presc;
    logic                   op_tick;
    logic [6:0]             div;
    logic                   shift_tick;
    logic                   sck_prev;
    logic                   rx_prev;
    logic                   rx_data;
    logic                   armed;
    logic                   start;
    logic                   irq;
  } state_t;

  state_t s_q;
  state_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler decode, used for both shared clocks

  // Code k up to 11 gives a tick every 2**k cycles; the top code follows the timer
  function automatic logic presc_tick(input logic [3:0] code,
                                      input logic [PRESC_CNT_W-1:0] cnt,
                                      input logic ext);
    logic t;
    t = 1'b0;
    if (code == PRESC_EXT_CODE)
      t = ext;
    else if (code <= PRESC_MAX_POW)
    begin
      t = 1'b1;
      for (int i = 0; i < PRESC_CNT_W; i++)
        if (i < int'(code))
          t = t & cnt[i];
    end
    return t;
  endfunction

  logic       tick_a;
  logic       tick_b;
  logic       wr_hit;
  logic       uart_inv;
  logic       sck_rise;
  logic       rx_edge;
  logic       div_done;
  op_mode_t   mode_sel;

  assign tick_a   = presc_tick(prescaler_select_reg[PRESC_A_LSB +: 4], s_q.presc, timer_tick);
  assign tick_b   = presc_tick(prescaler_select_reg[PRESC_B_LSB +: 4], s_q.presc, timer_tick);
  assign wr_hit   = wr_en & word_access & (addr == CH_ADDR) & unit_clock_gate;
  assign mode_sel = op_mode_t'(s_q.mode[MODE_FIELD_HI:MODE_FIELD_LO]);
  assign uart_inv = s_q.mode[RX_INVERT_BIT] & (mode_sel == MODE_UART);
  assign sck_rise = s_q.op_tick & sck_pin & ~s_q.sck_prev;
  assign rx_edge  = s_q.op_tick & (rxd_pin ^ s_q.rx_prev) & (uart_inv ? rxd_pin : ~rxd_pin);
  assign div_done = s_q.op_tick & (s_q.div == channel_data_div);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    s_d            = s_q;
    s_d.start      = 1'b0;
    s_d.presc      = s_q.presc + {{(PRESC_CNT_W-1){1'b0}}, 1'b1};

    // only the interrupt source bit moves while running
    if (wr_hit && channel_running_flag)
      s_d.mode[IRQ_SRC_BIT] = wdata[IRQ_SRC_BIT];
    else if (wr_hit)
      s_d.mode = (wdata & MODE_WRITE_MASK) | MODE_FIXED_ONES;
    // mode register held at its reset value while gated
    if (!unit_clock_gate)
      s_d.mode = MODE_RESET_VAL;

    if (rd_en)
      s_d.rdata = (addr != CH_ADDR) ? 16'h0000 :
                  (unit_clock_gate ? s_q.mode : MODE_RESET_VAL);

    s_d.op_tick = unit_clock_gate & (s_q.mode[OP_CLK_SEL_BIT] ? tick_b : tick_a);

    if (s_q.op_tick)
    begin
      s_d.sck_prev = sck_pin;
      s_d.rx_prev  = rxd_pin;
      s_d.rx_data  = rxd_pin ^ uart_inv;
    end

    if (!channel_running_flag || div_done)
      s_d.div = 7'h00;
    else if (s_q.op_tick)
      s_d.div = s_q.div + 7'h01;

    // one tick for all channel sub-units
    s_d.shift_tick = channel_running_flag &
                     (s_q.mode[SHIFT_SRC_BIT] ? sck_rise : div_done);

    if (s_q.armed && channel_running_flag &&
        (s_q.mode[START_TRIG_BIT] ? rx_edge : 1'b1))
    begin
      s_d.start = 1'b1;
      s_d.armed = 1'b0;
    end
    // A start write in the same cycle re-arms, so it is lost only while the unit clock gate is off
    if (channel_start_write && unit_clock_gate)
      s_d.armed = 1'b1;
    if (!unit_clock_gate)
      s_d.armed = 1'b0;

    s_d.irq = unit_clock_gate & (s_q.mode[IRQ_SRC_BIT] ? buf_empty_evt : xfer_end_evt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      s_q      <= '0;
      s_q.mode <= MODE_RESET_VAL;
    end
    else
      s_q <= s_d;
  end

  assign rdata               = s_q.rdata;
  assign channel_mode_reg    = s_q.mode;
  assign channel_op_clock    = s_q.op_tick;
  assign channel_shift_clock = s_q.shift_tick;
  assign transfer_start      = s_q.start;
  assign rx_data             = s_q.rx_data;
  assign channel_irq         = s_q.irq;
  assign op_mode             = s_q.mode[MODE_FIELD_HI:MODE_FIELD_LO];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  AST_RESET_VALUE: assert property (disable iff (1'b0)
    !resetn |=> s_q.mode == MODE_RESET_VAL)
    else $error("mode register not at reset value");

  AST_RUN_WRITE: assert property (
    wr_hit && channel_running_flag |=>
      s_q.mode[15:1] == $past(s_q.mode[15:1]) && s_q.mode[0] == $past(wdata[0]))
    else $error("running write changed more than interrupt source");

  AST_IDLE_WRITE: assert property (
    wr_hit && !channel_running_flag |=>
      s_q.mode == (($past(wdata) & MODE_WRITE_MASK) | MODE_FIXED_ONES))
    else $error("idle write not stored");

  AST_BYTE_IGNORED: assert property (
    wr_en && !word_access && unit_clock_gate |=> $stable(s_q.mode))
    else $error("byte write altered mode register");

  AST_GATE_OFF: assert property (
    !unit_clock_gate && rd_en && addr == CH_ADDR |=>
      s_q.mode == MODE_RESET_VAL && rdata == MODE_RESET_VAL)
    else $error("gated register not at default");

  AST_OP_CLOCK: assert property (
    channel_op_clock |-> $past(unit_clock_gate && (s_q.mode[15] ? tick_b : tick_a)))
    else $error("operation tick from wrong prescaler");

  AST_DIVIDED: assert property (
    div_done && channel_running_flag && !s_q.mode[SHIFT_SRC_BIT] |=> channel_shift_clock)
    else $error("divided shift tick missing");

  AST_START_ARMED: assert property (
    transfer_start |-> $past(s_q.armed) && (!s_q.armed || $past(channel_start_write))
      ##1 !transfer_start)
    else $error("start without prior arming");

  AST_UART_ONLY: assert property (
    s_q.op_tick && mode_sel != MODE_UART |=> rx_data == $past(rxd_pin))
    else $error("receive data inverted outside UART");

  AST_IRQ_SOURCE: assert property (
    channel_irq |-> $past(s_q.mode[0] ? buf_empty_evt : xfer_end_evt))
    else $error("interrupt from unselected source");

  COV_IDLE_WRITE: cover property (wr_hit && !channel_running_flag ##1 s_q.mode != MODE_RESET_VAL);
  COV_RX_START:   cover property (s_q.mode[START_TRIG_BIT] && transfer_start);
  COV_BUF_IRQ:    cover property (s_q.mode[IRQ_SRC_BIT] && channel_irq);
  COV_SCK_SHIFT:  cover property (s_q.mode[SHIFT_SRC_BIT] && channel_shift_clock);
  COV_RUN_WRITE:  cover property (wr_hit && channel_running_flag);

  ////////////////////////////////////////////////////////////////////////////
  // Fixed bit, clock, start, receive, gating and read hold checks

  AST_FIXED_BITS: assert property (
    (s_q.mode & ~MODE_WRITE_MASK) == MODE_FIXED_ONES)
    else $error("fixed mode bits not at their values");

  AST_NO_SHIFT_IDLE: assert property (
    !channel_running_flag |=> !channel_shift_clock)
    else $error("shift tick while channel stopped");

  AST_SCK_SHIFT: assert property (
    sck_rise && channel_running_flag && s_q.mode[SHIFT_SRC_BIT] |=> channel_shift_clock)
    else $error("pin clock edge gave no shift tick");

  AST_SW_START: assert property (
    s_q.armed && channel_running_flag && !s_q.mode[START_TRIG_BIT] |=> transfer_start)
    else $error("software start not taken");

  AST_RX_INVERT: assert property (
    s_q.op_tick && mode_sel == MODE_UART && s_q.mode[RX_INVERT_BIT] |=>
      rx_data == !$past(rxd_pin))
    else $error("receive data not inverted in UART");

  AST_GATE_DISARM: assert property (
    !unit_clock_gate |=> !s_q.armed)
    else $error("arming kept while unit gated");

  AST_OP_GATED: assert property (
    !unit_clock_gate |=> !channel_op_clock)
    else $error("operation tick while unit gated");

  AST_RDATA_HOLD: assert property (
    !rd_en |=> $stable(rdata))
    else $error("read data moved without a read");

endmodule

/* File: tb/far_peer.sv */
// External serial peer driving the clock and receive pins
`timescale 1ns/100ps
module far_peer (
  input  wire logic core_clk,
  input  wire logic sck_run,
  input  wire logic rx_level,
  output logic      sck_pin,
  output logic      rxd_pin
);
  logic [1:0] div_q = 2'h0;
  initial sck_pin = 1'b0;
  // slave clock pin
  // Clock stands low outside frames, toggles every 4 cycles inside
  always @(negedge core_clk)
  begin
    div_q <= sck_run ? div_q + 2'h1 : 2'h0;
    if (!sck_run)
      sck_pin <= 1'b0;
    else if (div_q == 2'h3)
      sck_pin <= ~sck_pin;
  end
  assign rxd_pin = rx_level;
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the channel mode register
`timescale 1ns/100ps
module tb;
  import chan_mode_pkg::*;
  logic        core_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, word_access = 1'b0;
  logic        rd_en = 1'b0, gate = 1'b1, run = 1'b0, start_wr = 1'b0, rd_pend = 1'b0;
  logic        rx_level = 1'b1, sck_run = 1'b0, xfer_evt = 1'b0, buf_evt = 1'b0;
  logic [19:0] addr = 20'h0;
  logic [15:0] wdata = 16'h0, v, exp_q[$];
  logic [7:0]  presc = 8'h20;
  logic [6:0]  div = 7'h2;
  wire  [15:0] rdata, mode;
  wire         sck, rxd, op_tick, sh_tick, t_start, rx_bit, irq;
  wire  [1:0]  op_mode;
  int          fail_count = 0, total_checks = 0;

  initial forever #2.5 core_clk = ~core_clk;

  serial_channel_mode_control uut (.core_clk(core_clk), .resetn(resetn), .addr(addr),
    .wr_en(wr_en), .word_access(word_access), .wdata(wdata), .rd_en(rd_en), .rdata(rdata),
    .unit_clock_gate(gate), .prescaler_select_reg(presc), .timer_tick(1'b0),
    .channel_data_div(div), .channel_running_flag(run), .channel_start_write(start_wr),
    .sck_pin(sck), .rxd_pin(rxd), .xfer_end_evt(xfer_evt), .buf_empty_evt(buf_evt),
    .channel_mode_reg(mode), .channel_op_clock(op_tick), .channel_shift_clock(sh_tick),
    .transfer_start(t_start), .rx_data(rx_bit), .channel_irq(irq), .op_mode(op_mode));
  far_peer peer (.core_clk(core_clk), .sck_run(sck_run), .rx_level(rx_level),
    .sck_pin(sck), .rxd_pin(rxd));

  //////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (fail_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [19:0] a, logic [15:0] d, logic w);
    @(negedge core_clk);
    addr = a;
    wdata = d;
    word_access = w;
    wr_en = 1'b1;
    @(negedge core_clk);
    wr_en = 1'b0;
  endtask
  task automatic rd(logic [19:0] a, logic [15:0] e);
    @(negedge core_clk);
    addr = a;
    rd_en = 1'b1;
    exp_q.push_back(e);
    @(negedge core_clk);
    rd_en = 1'b0;
  endtask
  // Tick counts drift by one with the free counter phase, so allow that
  task automatic cnt(int sel, int n, int e, string nm);
    int k;
    k = 0;
    repeat (n)
    begin
      @(negedge core_clk);
      k += (sel == 0) ? op_tick : (sel == 1) ? sh_tick : t_start;
    end
    chk(nm, 16'(e), 16'(((k - e) * (k - e) <= 1) ? e : k));
  endtask

  // Read results are compared against the oldest note
  always @(posedge core_clk) rd_pend <= rd_en;
  always @(negedge core_clk)
    if (rd_pend && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), rdata);

  initial
  begin
    #100us;
    fail_count++;
    tally_and_finish();
  end

  //////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(11046));
    repeat (2) @(negedge core_clk);
    resetn = 1'b1;
    rd(MODE_CH00_ADDR, MODE_RESET_VAL);
    for (int i = 0; i < 3; i++)
    begin
      v = ($urandom() & MODE_WRITE_MASK & 16'hfff9) | MODE_FIXED_ONES | 16'(i << 1);
      wr(MODE_CH00_ADDR, v, 1'b1);
      chk("op_mode", 16'(i), 16'(op_mode));
      rd(MODE_CH00_ADDR, v);
    end
    wr(MODE_CH00_ADDR, 16'h8023, 1'b0);
    wr(MODE_CH03_ADDR, 16'h8023, 1'b1);
    chk("mode", v, mode);
    rd(20'hf0112, 16'h0000);
    wr(MODE_CH00_ADDR, 16'h0020, 1'b1);
    cnt(0, 64, 64, "op_ticks_a");
    wr(MODE_CH00_ADDR, 16'h8020, 1'b1);
    cnt(0, 64, 16, "op_ticks_b");
    wr(MODE_CH00_ADDR, 16'h0020, 1'b1);
    run = 1'b1;
    cnt(1, 60, 20, "div_ticks");
    run = 1'b0;
    wr(MODE_CH00_ADDR, 16'h4020, 1'b1);
    run = 1'b1;
    sck_run = 1'b1;
    cnt(1, 64, 8, "sck_ticks");
    sck_run = 1'b0;
    // Deliberate write while running: only the interrupt select may move
    wr(MODE_CH00_ADDR, 16'hc147, 1'b1);
    chk("mode_run", 16'h4021, mode);
    run = 1'b0;
    for (int s = 0; s < 2; s++)
    begin
      wr(MODE_CH00_ADDR, 16'(16'h0020 | s), 1'b1);
      for (int e = 0; e < 2; e++)
      begin
        @(negedge core_clk);
        xfer_evt = (e == 0);
        buf_evt = (e == 1);
        @(negedge core_clk);
        xfer_evt = 1'b0;
        buf_evt = 1'b0;
        chk("irq", 16'(s == e), 16'(irq));
      end
    end
    wr(MODE_CH00_ADDR, 16'h0122, 1'b1);
    run = 1'b1;
    cnt(2, 4, 0, "start_unarmed");
    start_wr = 1'b1;
    @(negedge core_clk);
    start_wr = 1'b0;
    cnt(2, 6, 0, "start_no_edge");
    rx_level = 1'b0;
    cnt(2, 6, 1, "start_edge");
    run = 1'b0;
    wr(MODE_CH00_ADDR, 16'h0062, 1'b1);
    rx_level = 1'b1;
    repeat (3) @(negedge core_clk);
    chk("rx_uart", 16'h0, 16'(rx_bit));
    wr(MODE_CH00_ADDR, 16'h0060, 1'b1);
    repeat (3) @(negedge core_clk);
    chk("rx_csi", 16'h1, 16'(rx_bit));
    gate = 1'b0;
    wr(MODE_CH00_ADDR, 16'h8021, 1'b1);
    rd(MODE_CH00_ADDR, MODE_RESET_VAL);
    @(negedge core_clk);
    tally_and_finish();
  end
endmodule
